// [logic/bbp_pkg.sv]
// Constants, types and default tables for the boost/bypass pin control block.
// Assumes a single 125 MHz clock and a synchronous active-low reset.
//
// Operation
// - Rising enable edge reloads the role and current-limit registers with their defaults.
// - Enable low means shutdown, and serial interface traffic is ignored.
// - In shutdown, bypass-force picks pass-through or minimum-level output (3.6V delta).
// - Enable high gives automatic boost and pass-through operation.
// - Bypass-force driven low always forces pass-through.
// - First serial and first simple variants: threshold 3.15 V low, 3.35 V high.
// - Second simple variant: threshold 3.3 V low, 3.5 V high.
// - Low-voltage serial variant: threshold 3.4 V low, 3.45 V high.
// - Default valley current limit 3 A, 3 A, 4 A, 5 A per variant.
// - Multipurpose pin is mode select or reset/fault; defaults depend on variant.
// - Reset/fault role: falling edge starts discharge then fresh start-up.
// - Reset/fault role: faults pulse the open-drain pin low, then release it.
// - Mode select low: PWM at high load, PFM at light load.
// - Mode select high: low-noise setting, forced PWM at all loads.

`default_nettype none

package bbp_pkg;

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned DISCH_TIME_NS  = 20000;
  localparam int unsigned START_TIME_NS  = 30000;
  localparam int unsigned FAULT_PULSE_NS = 2000;
  localparam int unsigned CNT_W          = 12;
  // Least times round up to whole cycles
  localparam int unsigned DISCH_CYC = (DISCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_CYC = (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC = (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] DISCH_LAST = CNT_W'(DISCH_CYC - 1);
  localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
  // Readback of our own pulse needs sync latency plus margin to die out
  localparam logic [2:0]       BLANK_LAST = 3'h4;

  // -----------------------------------------------------------------
  // Pin synchroniser lanes
  // -----------------------------------------------------------------
  localparam int unsigned NPINS     = 7;
  localparam int unsigned PIN_EN    = 0;
  localparam int unsigned PIN_BYP   = 1;
  localparam int unsigned PIN_SEL   = 2;
  localparam int unsigned PIN_MPP   = 3;
  localparam int unsigned PIN_FTSD  = 4;
  localparam int unsigned PIN_FVOUT = 5;
  localparam int unsigned PIN_FILIM = 6;
  localparam logic [NPINS-1:0] PIN_RST = 7'h0a;

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    VAR_I2C_A   = 2'h0,
    VAR_LOGIC_A = 2'h1,
    VAR_LOGIC_B = 2'h2,
    VAR_I2C_LV  = 2'h3
  } bbp_variant_type;

  typedef enum logic {
    ROLE_RST_FAULT = 1'h0,
    ROLE_MODE_SEL  = 1'h1
  } bbp_role_type;

  typedef enum logic [1:0] {
    OP_SHDN_MIN  = 2'h0,
    OP_SHDN_PASS = 2'h1,
    OP_PASS      = 2'h3,
    OP_AUTO      = 2'h2
  } bbp_op_type;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h0,
    SEQ_DISCH = 2'h1,
    SEQ_START = 2'h3
  } bbp_seq_type;

  // -----------------------------------------------------------------
  // Variant tables (thresholds in 10 mV, limits in amperes)
  // -----------------------------------------------------------------
  localparam logic [8:0] THR_315     = 9'h13b;
  localparam logic [8:0] THR_335     = 9'h14f;
  localparam logic [8:0] THR_330     = 9'h14a;
  localparam logic [8:0] THR_350     = 9'h15e;
  localparam logic [8:0] THR_340     = 9'h154;
  localparam logic [8:0] THR_345     = 9'h159;
  localparam logic [8:0] SHDN_DELTA  = 9'h168;
  localparam logic [2:0] ILIM_3A     = 3'h3;
  localparam logic [2:0] ILIM_4A     = 3'h4;
  localparam logic [2:0] ILIM_5A     = 3'h5;

  function automatic logic [8:0] thr_f(input bbp_variant_type v, input logic sel);
    unique case (v)
      VAR_LOGIC_B: thr_f = sel ? THR_350 : THR_330;
      VAR_I2C_LV:  thr_f = sel ? THR_345 : THR_340;
      default:     thr_f = sel ? THR_335 : THR_315;
    endcase
  endfunction : thr_f

  function automatic logic [2:0] ilim_dflt_f(input bbp_variant_type v);
    unique case (v)
      VAR_LOGIC_B: ilim_dflt_f = ILIM_4A;
      VAR_I2C_LV:  ilim_dflt_f = ILIM_5A;
      default:     ilim_dflt_f = ILIM_3A;
    endcase
  endfunction : ilim_dflt_f

  function automatic bbp_role_type role_dflt_f(input bbp_variant_type v);
    role_dflt_f = (v == VAR_I2C_LV) ? ROLE_MODE_SEL : ROLE_RST_FAULT;
  endfunction : role_dflt_f

endpackage : bbp_pkg

`default_nettype wire

// [logic/bbp_pin_sync.sv]
// Three-stage synchroniser bank with agreement filter and edge pulses.
// Assumes pins are asynchronous to sys_clk_i; all outputs are flops.

`default_nettype none

module bbp_pin_sync
  import bbp_pkg::*;
#(
  parameter int unsigned          N    = NPINS,
  parameter logic [NPINS-1:0]     RSTV = PIN_RST
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [N-1:0] pin_i,
  output logic      [N-1:0] level_o,
  output logic      [N-1:0] rise_o,
  output logic      [N-1:0] fall_o
);

  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lane
      always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
          s1_r[g]    <= RSTV[g];
          s2_r[g]    <= RSTV[g];
          s3_r[g]    <= RSTV[g];
          level_o[g] <= RSTV[g];
          rise_o[g]  <= 1'b0;
          fall_o[g]  <= 1'b0;
        end else begin
          s1_r[g] <= pin_i[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // Change counts only when stages two and three agree
          if (s2_r[g] == s3_r[g] && s3_r[g] != level_o[g]) begin
            level_o[g] <= s3_r[g];
            rise_o[g]  <= s3_r[g];
            fall_o[g]  <= !s3_r[g];
          end else begin
            rise_o[g] <= 1'b0;
            fall_o[g] <= 1'b0;
          end
        end
      end

      sync_agree_a: assert property ($changed(level_o[g]) |->
          $past(s2_r[g]) == $past(s3_r[g]) && rise_o[g] == level_o[g])
        else $error("synchronised level changed without stage agreement");
    end
  endgenerate

endmodule : bbp_pin_sync

`default_nettype wire

// [logic/bbp_reset_seq.sv]
// Manual reset sequence: output discharge phase, then start-up phase.
// Assumes trig_i is a one-cycle pulse from the synchronised pin.

`default_nettype none

module bbp_reset_seq
  import bbp_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  input  wire logic trig_i,
  output logic      discharge_o,
  output logic      startup_o
);

  bbp_seq_type      state_r;
  logic [CNT_W-1:0] cnt_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  // Phase outputs move with the state so they leave the block as flops
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !run_i) begin
      state_r     <= SEQ_IDLE;
      cnt_r       <= '0;
      discharge_o <= 1'b0;
      startup_o   <= 1'b0;
    end else begin
      unique case (state_r)
        SEQ_IDLE: begin
          cnt_r <= '0;
          if (trig_i) begin
            state_r     <= SEQ_DISCH;
            discharge_o <= 1'b1;
          end
        end
        SEQ_DISCH: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == DISCH_LAST) begin
            state_r     <= SEQ_START;
            cnt_r       <= '0;
            discharge_o <= 1'b0;
            startup_o   <= 1'b1;
          end
        end
        SEQ_START: begin
          cnt_r <= cnt_r + 1'b1;
          // A new edge during start-up restarts the whole sequence
          if (trig_i) begin
            state_r     <= SEQ_DISCH;
            cnt_r       <= '0;
            discharge_o <= 1'b1;
            startup_o   <= 1'b0;
          end else if (cnt_r == START_LAST) begin
            state_r   <= SEQ_IDLE;
            startup_o <= 1'b0;
          end
        end
        default: begin
          state_r     <= SEQ_IDLE;
          discharge_o <= 1'b0;
          startup_o   <= 1'b0;
        end
      endcase
    end
  end

  disch_then_start_a: assert property ($fell(discharge_o) && run_i |-> startup_o)
    else $error("discharge phase not followed by start-up");

  disch_hold_a: assert property ($rose(discharge_o) && run_i |-> discharge_o [*8])
    else $error("discharge phase ended too early");

endmodule : bbp_reset_seq

`default_nettype wire

// [logic/bbp_ctrl.sv]
// Top of the boost/bypass pin control: pin decode, operating mode,
// default registers, multipurpose pin roles and fault pulse output.
// Assumes pins are asynchronous and cfg_* comes from the serial block on sys_clk_i.

`default_nettype none

module bbp_ctrl
  import bbp_pkg::*;
#(
  parameter bbp_variant_type VARIANT = VAR_I2C_A
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       enable_i,
  input  wire logic       bypass_force_n_i,
  input  wire logic       threshold_select_i,
  input  wire logic       reset_fault_pin_n_i,
  input  wire logic       fault_thermal_i,
  input  wire logic       fault_vout_i,
  input  wire logic       fault_ilim_i,
  input  wire logic       cfg_wr_i,
  input  wire logic       cfg_role_i,
  input  wire logic [2:0] cfg_ilim_i,
  output logic            serial_en_o,
  output logic      [1:0] op_mode_o,
  output logic      [8:0] shdn_delta_o,
  output logic      [8:0] threshold_o,
  output logic      [2:0] ilim_amp_o,
  output logic            role_mode_sel_o,
  output logic            pfm_allowed_o,
  output logic            pwm_forced_o,
  output logic            low_noise_o,
  output logic            reset_fault_pin_n_o,
  output logic            reset_fault_pin_n_oe_o,
  output logic            discharge_o,
  output logic            startup_o
);

  // -----------------------------------------------------------------
  // Pin synchronisation
  // -----------------------------------------------------------------
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_lvl;
  logic [NPINS-1:0] pin_rise;
  logic [NPINS-1:0] pin_fall;

  assign pin_raw = {fault_ilim_i, fault_vout_i, fault_thermal_i, reset_fault_pin_n_i,
                    threshold_select_i, bypass_force_n_i, enable_i};

  bbp_pin_sync #(
    .N    (NPINS),
    .RSTV (PIN_RST)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_raw),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  logic en_lvl;
  logic en_rise;
  logic byp_n_lvl;
  logic sel_lvl;
  logic mpp_lvl;
  logic mpp_fall;
  logic fault_ev;

  assign en_lvl    = pin_lvl[PIN_EN];
  assign en_rise   = pin_rise[PIN_EN];
  assign byp_n_lvl = pin_lvl[PIN_BYP];
  assign sel_lvl   = pin_lvl[PIN_SEL];
  assign mpp_lvl   = pin_lvl[PIN_MPP];
  assign mpp_fall  = pin_fall[PIN_MPP];
  assign fault_ev  = pin_rise[PIN_FTSD] | pin_rise[PIN_FVOUT] | pin_rise[PIN_FILIM];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // -----------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------
  bbp_role_type role_r;

  // Enable edge wins over a write in the same cycle; writes need enable high
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || en_rise) begin
      role_r     <= role_dflt_f(VARIANT);
      ilim_amp_o <= ilim_dflt_f(VARIANT);
    end else if (cfg_wr_i && en_lvl) begin
      role_r     <= bbp_role_type'(cfg_role_i);
      ilim_amp_o <= cfg_ilim_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      role_mode_sel_o <= 1'b0;
    end else begin
      role_mode_sel_o <= (role_r == ROLE_MODE_SEL);
    end
  end

  // -----------------------------------------------------------------
  // Serial interface gate
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      serial_en_o <= 1'b0;
    end else begin
      serial_en_o <= en_lvl;
    end
  end

  // -----------------------------------------------------------------
  // Operating mode
  // -----------------------------------------------------------------
  bbp_op_type op_nxt;

  always_comb begin
    if (!en_lvl) begin
      op_nxt = byp_n_lvl ? OP_SHDN_MIN : OP_SHDN_PASS;
    end else if (!byp_n_lvl) begin
      op_nxt = OP_PASS;
    end else begin
      op_nxt = OP_AUTO;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      op_mode_o    <= OP_SHDN_MIN;
      shdn_delta_o <= SHDN_DELTA;
    end else begin
      op_mode_o    <= op_nxt;
      // Delta limit holds only while regulating the minimum level in shutdown
      shdn_delta_o <= (op_nxt == OP_SHDN_MIN) ? SHDN_DELTA : '0;
    end
  end

  // -----------------------------------------------------------------
  // Threshold select
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      threshold_o <= thr_f(VARIANT, 1'b0);
    end else begin
      threshold_o <= thr_f(VARIANT, sel_lvl);
    end
  end

  // -----------------------------------------------------------------
  // Modulation setting
  // -----------------------------------------------------------------
  logic forced_pwm;

  // Reset/fault role has no mode input, so light-load PFM stays allowed
  assign forced_pwm = (role_r == ROLE_MODE_SEL) && mpp_lvl;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pfm_allowed_o <= 1'b1;
      pwm_forced_o  <= 1'b0;
      low_noise_o   <= 1'b0;
    end else begin
      pfm_allowed_o <= !forced_pwm;
      pwm_forced_o  <= forced_pwm;
      low_noise_o   <= forced_pwm;
    end
  end

  // -----------------------------------------------------------------
  // Fault pulse on the open-drain pin
  // -----------------------------------------------------------------
  logic             rf_role;
  logic [CNT_W-1:0] pulse_cnt_r;
  logic [2:0]       blank_cnt_r;
  logic             blank_r;

  assign rf_role = en_lvl && (role_r == ROLE_RST_FAULT);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !rf_role) begin
      reset_fault_pin_n_oe_o <= 1'b0;
      pulse_cnt_r            <= '0;
    end else if (reset_fault_pin_n_oe_o) begin
      pulse_cnt_r <= pulse_cnt_r + 1'b1;
      if (pulse_cnt_r == PULSE_LAST) begin
        reset_fault_pin_n_oe_o <= 1'b0;
      end
    end else if (fault_ev) begin
      reset_fault_pin_n_oe_o <= 1'b1;
      pulse_cnt_r            <= '0;
    end
  end

  // Open drain only ever drives low
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      reset_fault_pin_n_o <= 1'b0;
    end else begin
      reset_fault_pin_n_o <= 1'b0;
    end
  end

  // Our own pulse reads back low; blank it so it never starts a reset
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      blank_cnt_r <= '0;
      blank_r     <= 1'b0;
    end else if (reset_fault_pin_n_oe_o) begin
      blank_cnt_r <= '0;
      blank_r     <= 1'b1;
    end else if (blank_r) begin
      blank_cnt_r <= blank_cnt_r + 1'b1;
      if (blank_cnt_r == BLANK_LAST) begin
        blank_r <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Manual reset sequence
  // -----------------------------------------------------------------
  logic mr_trig;

  assign mr_trig = mpp_fall && !reset_fault_pin_n_oe_o && !blank_r;

  bbp_reset_seq u_seq (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .run_i       (rf_role),
    .trig_i      (mr_trig),
    .discharge_o (discharge_o),
    .startup_o   (startup_o)
  );

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  en_reload_a: assert property (en_rise |=>
      ilim_amp_o == ilim_dflt_f(VARIANT) && role_r == role_dflt_f(VARIANT))
    else $error("enable rising edge did not reload defaults");

  serial_gate_a: assert property (!en_lvl |=> !serial_en_o && $stable(role_r))
    else $error("serial interface active or written while disabled");

  shdn_mode_a: assert property (!en_lvl |=>
      op_mode_o == ($past(byp_n_lvl) ? OP_SHDN_MIN : OP_SHDN_PASS))
    else $error("shutdown mode does not follow bypass-force");

  auto_mode_a: assert property (en_lvl && byp_n_lvl |=> op_mode_o == OP_AUTO)
    else $error("enabled device not in automatic operation");

  bypass_force_a: assert property (!byp_n_lvl |=>
      op_mode_o == OP_PASS || op_mode_o == OP_SHDN_PASS)
    else $error("bypass-force low did not give pass-through");

  thr_table_a: assert property (##1 threshold_o == thr_f(VARIANT, $past(sel_lvl)))
    else $error("threshold does not match variant table");

  ilim_default_a: assert property ($rose(en_lvl) |=> ilim_amp_o == ilim_dflt_f(VARIANT))
    else $error("current limit default wrong after enable");

  pulse_role_a: assert property ($rose(reset_fault_pin_n_oe_o) |->
      role_r == ROLE_RST_FAULT && !reset_fault_pin_n_o ##1 reset_fault_pin_n_oe_o [*7])
    else $error("fault pulse wrong role or too short");

  pulse_release_a: assert property (reset_fault_pin_n_oe_o && pulse_cnt_r == PULSE_LAST |=>
      !reset_fault_pin_n_oe_o)
    else $error("fault pulse not released");

  mode_sel_a: assert property (en_lvl && role_r == ROLE_MODE_SEL |=>
      pwm_forced_o == $past(mpp_lvl) && low_noise_o == $past(mpp_lvl)
      && pfm_allowed_o == !$past(mpp_lvl))
    else $error("modulation does not follow mode-select pin");

  // -----------------------------------------------------------------
  // Role, pulse and sequence start, serial gate, configuration and delta checks
  // -----------------------------------------------------------------
  fault_start_a: assert property (rf_role && fault_ev && !reset_fault_pin_n_oe_o |=>
      reset_fault_pin_n_oe_o)
    else $error("fault event did not start a pulse");

  mr_start_a: assert property (mr_trig && rf_role && !discharge_o |=> discharge_o)
    else $error("manual reset edge did not start discharge");

  no_pulse_role_a: assert property (!rf_role |=> !reset_fault_pin_n_oe_o)
    else $error("fault pulse outside reset/fault role");

  no_seq_role_a: assert property (!rf_role |=> !discharge_o && !startup_o)
    else $error("reset sequence outside reset/fault role");

  serial_follow_a: assert property (en_lvl |=> serial_en_o)
    else $error("serial interface not enabled with enable high");

  cfg_take_a: assert property (cfg_wr_i && en_lvl && !en_rise |=>
      ilim_amp_o == $past(cfg_ilim_i) && role_r == bbp_role_type'($past(cfg_role_i)))
    else $error("configuration write not taken while enabled");

  delta_min_a: assert property (!en_lvl && byp_n_lvl |=> shdn_delta_o == SHDN_DELTA)
    else $error("minimum-level delta limit missing in shutdown");

endmodule : bbp_ctrl

`default_nettype wire

// [dv/bbp_host_model.sv]
// Host side of the shared reset/fault line: open-drain host drive plus board pull-up.
// Assumes the device pin drive value and enable come straight from the block ports.

`default_nettype none

module bbp_host_model (
  input  wire logic host_low_i,
  input  wire logic dev_pin_i,
  input  wire logic dev_oe_i,
  output wire logic line_o
);
  // -----------------------------------------------------------------
  // Wire resolution
  // -----------------------------------------------------------------
  // Pull-up terminates the line, so it never floats when both sides let go
  assign line_o = !(host_low_i || (dev_oe_i && !dev_pin_i));
endmodule : bbp_host_model

`default_nettype wire

// [dv/test_bbp_ctrl.sv]
// Self-checking bench: four variants of the pin control share one set of pins.
// Assumes the host model resolves the reset/fault line of the first instance.

`default_nettype none

module test_bbp_ctrl
  import bbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  logic            sys_clk_i, rstn_i, en, byp_n, sel, host_low, cfg_wr, cfg_role;
  logic [2:0]      flt, cfg_ilim;
  wire             line;
  wire  [3:0]      ser_en, role_ms, pfm, pwm, lnoise, pin_n, oe, dis, stu;
  wire  [3:0][1:0] op;
  wire  [3:0][8:0] shd, thr;
  wire  [3:0][2:0] ilim;
  logic [3:0][8:0] thr_lo = {THR_340, THR_330, THR_315, THR_315};
  logic [3:0][8:0] thr_hi = {THR_345, THR_350, THR_335, THR_335};
  logic [3:0][2:0] il_d   = {ILIM_5A, ILIM_4A, ILIM_3A, ILIM_3A};
  int              n_fail = 0, cmp_count = 0, cyc = 0, n;

  for (genvar v = 0; v < 4; v++) begin : g_var
    bbp_ctrl #(.VARIANT(bbp_variant_type'(v))) bbp_ctrl_inst (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .enable_i(en), .bypass_force_n_i(byp_n),
      .threshold_select_i(sel), .reset_fault_pin_n_i(line), .fault_thermal_i(flt[0]),
      .fault_vout_i(flt[1]), .fault_ilim_i(flt[2]), .cfg_wr_i(cfg_wr),
      .cfg_role_i(cfg_role), .cfg_ilim_i(cfg_ilim), .serial_en_o(ser_en[v]),
      .op_mode_o(op[v]), .shdn_delta_o(shd[v]), .threshold_o(thr[v]),
      .ilim_amp_o(ilim[v]), .role_mode_sel_o(role_ms[v]), .pfm_allowed_o(pfm[v]),
      .pwm_forced_o(pwm[v]), .low_noise_o(lnoise[v]), .reset_fault_pin_n_o(pin_n[v]),
      .reset_fault_pin_n_oe_o(oe[v]), .discharge_o(dis[v]), .startup_o(stu[v]));
  end

  bbp_host_model bbp_host_model_inst (
    .host_low_i(host_low), .dev_pin_i(pin_n[0]), .dev_oe_i(oe[0]), .line_o(line));

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Sample just after the edge so that edge's updates have landed
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : wt

  task automatic cfg(input logic r, input logic [2:0] il);
    @(posedge sys_clk_i);
    cfg_wr   <= 1'b1;
    cfg_role <= r;
    cfg_ilim <= il;
    @(posedge sys_clk_i);
    cfg_wr <= 1'b0;
    wt(3);
  endtask : cfg

  function automatic logic pick(input int k);
    return (k == 0) ? oe[0] : ((k == 1) ? dis[0] : stu[0]);
  endfunction : pick

  // Length in cycles of the next high phase; zero if it never starts
  task automatic hi_len(input int k, output int len);
    int w;
    w   = 0;
    len = 0;
    while (pick(k) !== 1'b1 && w < 20) begin
      wt(1);
      w++;
    end
    while (pick(k) === 1'b1 && len < 8000) begin
      wt(1);
      len++;
    end
  endtask : hi_len

  // -----------------------------------------------------------------
  // Clock, timeout and sequence
  // -----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    rstn_i   = 1'b0;
    en       = 1'b0;
    byp_n    = 1'b1;
    sel      = 1'b0;
    host_low = 1'b0;
    cfg_wr   = 1'b0;
    cfg_role = 1'b0;
    cfg_ilim = 3'h0;
    flt      = 3'h0;
    wt(20);
    @(posedge sys_clk_i) rstn_i <= 1'b1;
    wt(4);
    for (int v = 0; v < 4; v++) begin
      chk("threshold_low", 12'(thr_lo[v]), 12'(thr[v]));
      chk("ilim_default", 12'(il_d[v]), 12'(ilim[v]));
      chk("role_default", 12'(v == 3), 12'(role_ms[v]));
    end
    chk("op_shdn", 12'(OP_SHDN_MIN), 12'(op[0]));
    chk("delta", 12'(SHDN_DELTA), 12'(shd[0]));
    chk("serial_off", 12'h000, 12'(ser_en[0]));
    @(posedge sys_clk_i) byp_n <= 1'b0;
    wt(8);
    chk("op_shdn_pass", 12'(OP_SHDN_PASS), 12'(op[0]));
    chk("delta_pass", 12'h000, 12'(shd[0]));
    @(posedge sys_clk_i) byp_n <= 1'b1;
    cfg(1'b1, 3'h5);
    chk("ilim_ignored", 12'(ILIM_3A), 12'(ilim[0]));
    @(posedge sys_clk_i) en <= 1'b1;
    wt(8);
    chk("serial_on", 12'h001, 12'(ser_en[0]));
    chk("op_auto", 12'(OP_AUTO), 12'(op[0]));
    @(posedge sys_clk_i) byp_n <= 1'b0;
    wt(8);
    chk("op_pass", 12'(OP_PASS), 12'(op[0]));
    @(posedge sys_clk_i) byp_n <= 1'b1;
    @(posedge sys_clk_i) sel <= 1'b1;
    wt(8);
    for (int v = 0; v < 4; v++) begin
      chk("threshold_high", 12'(thr_hi[v]), 12'(thr[v]));
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk_i) flt <= 3'(1 << k);
      hi_len(0, n);
      chk("fault_pulse", 12'(PULSE_CYC), 12'(n));
      chk("pin_drive", 12'h000, 12'(pin_n[0]));
      @(posedge sys_clk_i) flt <= 3'h0;
      wt(12);
    end
    @(posedge sys_clk_i) host_low <= 1'b1;
    hi_len(1, n);
    chk("discharge_len", 12'(DISCH_CYC), 12'(n));
    hi_len(2, n);
    chk("startup_len", 12'(START_CYC), 12'(n));
    @(posedge sys_clk_i) host_low <= 1'b0;
    wt(8);
    cfg(1'b1, 3'h4);
    wt(2);
    chk("ilim_written", 12'(ILIM_4A), 12'(ilim[0]));
    chk("role_written", 12'h001, 12'(role_ms[0]));
    chk("pwm_forced", 12'h001, 12'(pwm[0]));
    chk("low_noise", 12'h001, 12'(lnoise[0]));
    chk("pfm_off", 12'h000, 12'(pfm[0]));
    @(posedge sys_clk_i) host_low <= 1'b1;
    wt(10);
    chk("pfm", 12'h001, 12'(pfm[0]));
    chk("pwm_auto", 12'h000, 12'(pwm[0]));
    chk("no_discharge", 12'h000, 12'(dis[0]));
    @(posedge sys_clk_i) flt <= 3'h1;
    wt(10);
    chk("no_pulse", 12'h000, 12'(oe[0]));
    @(posedge sys_clk_i) flt <= 3'h0;
    @(posedge sys_clk_i) en <= 1'b0;
    wt(8);
    @(posedge sys_clk_i) en <= 1'b1;
    wt(8);
    chk("ilim_reload", 12'(ILIM_3A), 12'(ilim[0]));
    chk("role_reload", 12'h000, 12'(role_ms[0]));
    summarize();
  end
endmodule : test_bbp_ctrl

`default_nettype wire
